// *** cmbs_pkg.sv ***
// Constants, carriers and identifier mapping for the CAN message buffer store.
// Assumes a byte-wide CPU port and a CAN protocol engine on the same clock.
//=============================================
package cmbs_pkg;
	//=============================================
	// Address map
	localparam int         ADDR_W    = 12;
	localparam int         NIB_LSB   = 4;
	localparam logic [1:0] BUF_TAG   = 2'h1;
	localparam int         NUM_TX    = 3;
	localparam int         NUM_BUF   = 4;
	localparam logic [3:0] OFF_ID0   = 4'h0;
	localparam logic [3:0] OFF_DATA0 = 4'h4;
	localparam logic [3:0] OFF_LEN   = 4'hc;
	localparam logic [3:0] OFF_PRIO  = 4'hd;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	//=============================================
	// Identifier byte fields
	localparam int ID1_LSB     = 16;
	localparam int SRR_BIT     = 4;
	localparam int IDE_BIT     = 3;
	localparam int RTR_STD_BIT = 4;
	localparam int RTR_EXT_BIT = 0;
	//=============================================
	// Carriers
	typedef struct packed {
		logic [28:0] id;
		logic        srr;
		logic        ide;
		logic        rtr;
		logic [3:0]  dlc;
	} cmbs_hdr_t;
	typedef struct packed {
		logic              sel;
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} cmbs_cpu_t;
	typedef enum logic {CMBS_IDLE, CMBS_SEND} cmbs_state_t;
	//=============================================
	// Functions
	function automatic logic [3:0] cmbs_count(input logic [3:0] dlc);
		cmbs_count = (dlc > MAX_BYTES) ? MAX_BYTES : dlc;
	endfunction : cmbs_count
	function automatic logic [31:0] cmbs_id_pack(input cmbs_hdr_t h);
		if (h.ide) begin
			cmbs_id_pack = {h.id[28:21], h.id[20:18], h.srr, 1'b1, h.id[17:15],
			                h.id[14:7], h.id[6:0], h.rtr};
		end else begin
			cmbs_id_pack = {h.id[10:3], h.id[2:0], h.rtr, 1'b0, 3'h0, 16'h0000};
		end
	endfunction : cmbs_id_pack
	function automatic cmbs_hdr_t cmbs_id_unpack(input logic [31:0] b, input logic [7:0] len);
		cmbs_id_unpack     = '0;
		cmbs_id_unpack.ide = b[ID1_LSB+IDE_BIT];
		cmbs_id_unpack.dlc = len[3:0];
		if (b[ID1_LSB+IDE_BIT]) begin
			cmbs_id_unpack.id  = {b[31:21], b[18:16], b[15:8], b[7:1]};
			cmbs_id_unpack.srr = b[ID1_LSB+SRR_BIT];
			cmbs_id_unpack.rtr = b[RTR_EXT_BIT];
		end else begin
			cmbs_id_unpack.id  = {18'h00000, b[31:21]};
			cmbs_id_unpack.rtr = b[ID1_LSB+RTR_STD_BIT];
		end
	endfunction : cmbs_id_unpack
endpackage : cmbs_pkg

// *** cmbs_store.sv ***
// Message buffer store: one receive and three transmit buffers with send selection.
// Assumes CPU strobes, engine strobes and empty flags all come from logic on clk.
`timescale 1ns/100ps
module cmbs_store (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// CPU port
	input  wire cmbs_pkg::cmbs_cpu_t cpu,
	output logic [7:0]             cpu_rdata,
	// Receive side from the protocol engine
	input  wire logic              rx_hdr_we,
	input  wire cmbs_pkg::cmbs_hdr_t rx_hdr,
	input  wire logic              rx_byte_we,
	input  wire logic [2:0]        rx_byte_idx,
	input  wire logic [7:0]        rx_byte,
	// Transmit selection
	input  wire logic [2:0]        tx_empty,
	input  wire logic              sof_req,
	output logic                   tx_hdr_valid,
	output cmbs_pkg::cmbs_hdr_t    tx_hdr,
	output logic [1:0]             tx_buf_idx,
	output logic                   tx_none,
	output logic                   tx_done,
	// Transmit data stream
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	input  wire logic              tx_ready
);
	import cmbs_pkg::*;

	//=============================================
	// Storage
	logic [7:0] mem [0:NUM_BUF-1][0:OFF_PRIO];

	function automatic logic is_buf(input logic [ADDR_W-1:0] a);
		is_buf = (a[NIB_LSB+3:NIB_LSB+2] == BUF_TAG);
	endfunction : is_buf
	function automatic logic [1:0] buf_of(input logic [ADDR_W-1:0] a);
		buf_of = a[NIB_LSB+1:NIB_LSB];
	endfunction : buf_of

	logic [3:0] cpu_off;
	logic [1:0] cpu_buf;
	logic       cpu_tx_wr;
	logic       rx_fill_ok;
	logic [3:0] rx_count;
	assign cpu_off    = cpu.addr[3:0];
	assign cpu_buf    = buf_of(cpu.addr);
	assign cpu_tx_wr  = cpu.sel && cpu.wr && is_buf(cpu.addr) && (cpu_buf != 2'h0)
	                    && (cpu_off <= OFF_PRIO);
	assign rx_count   = cmbs_count(mem[0][OFF_LEN][3:0]);
	assign rx_fill_ok = rx_byte_we && ({1'b0, rx_byte_idx} < rx_count);

	// No reset on buffer bytes
	always_ff @(posedge clk) begin
		if (cpu_tx_wr) begin
			mem[cpu_buf][cpu_off] <= cpu.wdata;
		end
		if (rx_hdr_we) begin
			{mem[0][0], mem[0][1], mem[0][2], mem[0][3]} <= cmbs_id_pack(rx_hdr);
			mem[0][OFF_LEN] <= {4'h0, rx_hdr.dlc};
		end else if (rx_fill_ok) begin
			mem[0][OFF_DATA0 + {1'b0, rx_byte_idx}] <= rx_byte;
		end
	end

	//=============================================
	// CPU read
	logic [7:0] next_cpu_rdata;
	always_comb begin
		next_cpu_rdata = 8'h00;
		if (cpu.sel && cpu.rd && is_buf(cpu.addr)) begin
			if (cpu_off <= OFF_LEN) begin
				next_cpu_rdata = mem[cpu_buf][cpu_off];
			end else if (cpu_off == OFF_PRIO && cpu_buf != 2'h0) begin
				next_cpu_rdata = mem[cpu_buf][OFF_PRIO];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			cpu_rdata <= 8'h00;
		end else begin
			cpu_rdata <= next_cpu_rdata;
		end
	end

	//=============================================
	// Priority selection
	logic       win_any;
	logic [1:0] win_idx;
	logic [7:0] win_prio;
	always_comb begin
		win_any  = 1'b0;
		win_idx  = 2'h0;
		win_prio = 8'hff;
		for (int i = 0; i < NUM_TX; i++) begin
			if (!tx_empty[i] && (!win_any || mem[i+1][OFF_PRIO] < win_prio)) begin
				win_any  = 1'b1;
				win_idx  = 2'(i);
				win_prio = mem[i+1][OFF_PRIO];
			end
		end
	end

	//=============================================
	// Two-entry output buffer
	logic [7:0] spare;
	logic       spare_v;
	logic       in_ready;
	logic       push;
	logic       pop;
	logic [7:0] push_data;
	logic [7:0] next_tx_data;
	logic [7:0] next_spare;
	logic       next_tx_valid;
	logic       next_spare_v;
	assign in_ready = !spare_v;
	assign pop      = tx_valid && tx_ready;
	always_comb begin
		next_tx_data  = tx_data;
		next_tx_valid = tx_valid;
		next_spare    = spare;
		next_spare_v  = spare_v;
		if (pop) begin
			if (spare_v) begin
				next_tx_data = spare;
				next_spare_v = 1'b0;
			end else begin
				next_tx_data  = push_data;
				next_tx_valid = push;
			end
		end else if (push) begin
			if (!tx_valid) begin
				next_tx_data  = push_data;
				next_tx_valid = 1'b1;
			end else begin
				next_spare   = push_data;
				next_spare_v = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_data  <= 8'h00;
			tx_valid <= 1'b0;
			spare    <= 8'h00;
			spare_v  <= 1'b0;
		end else begin
			tx_data  <= next_tx_data;
			tx_valid <= next_tx_valid;
			spare    <= next_spare;
			spare_v  <= next_spare_v;
		end
	end

	//=============================================
	// Send sequencer
	cmbs_state_t st;
	cmbs_state_t next_st;
	logic [3:0]  cnt;
	logic [3:0]  total;
	logic [3:0]  next_cnt;
	logic [3:0]  next_total;
	cmbs_hdr_t   next_hdr;
	cmbs_hdr_t   win_hdr;
	logic [1:0]  next_idx;
	logic        next_hv;
	logic        next_none;
	logic        next_done;
	logic [1:0]  wb;
	assign wb      = win_idx + 2'h1;
	assign win_hdr = cmbs_id_unpack({mem[wb][0], mem[wb][1], mem[wb][2], mem[wb][3]},
	                                mem[wb][OFF_LEN]);
	assign push_data = mem[tx_buf_idx + 2'h1][OFF_DATA0 + cnt];
	always_comb begin
		next_st    = st;
		next_cnt   = cnt;
		next_total = total;
		next_hdr   = tx_hdr;
		next_idx   = tx_buf_idx;
		next_hv    = tx_hdr_valid;
		next_none  = 1'b0;
		next_done  = 1'b0;
		push       = 1'b0;
		case (st)
			CMBS_IDLE: begin
				if (sof_req) begin
					if (win_any) begin
						next_hdr   = win_hdr;
						next_idx   = win_idx;
						next_hv    = 1'b1;
						next_cnt   = 4'h0;
						next_total = win_hdr.rtr ? 4'h0 : cmbs_count(win_hdr.dlc);
						next_st    = CMBS_SEND;
					end else begin
						next_none = 1'b1;
					end
				end
			end
			CMBS_SEND: begin
				if (cnt < total && in_ready) begin
					push     = 1'b1;
					next_cnt = cnt + 4'h1;
				end
				if (cnt == total && !tx_valid && !spare_v) begin
					next_done = 1'b1;
					next_hv   = 1'b0;
					next_st   = CMBS_IDLE;
				end
			end
			default: begin
				next_st = CMBS_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			st           <= CMBS_IDLE;
			cnt          <= 4'h0;
			total        <= 4'h0;
			tx_hdr       <= '0;
			tx_buf_idx   <= 2'h0;
			tx_hdr_valid <= 1'b0;
			tx_none      <= 1'b0;
			tx_done      <= 1'b0;
		end else begin
			st           <= next_st;
			cnt          <= next_cnt;
			total        <= next_total;
			tx_hdr       <= next_hdr;
			tx_buf_idx   <= next_idx;
			tx_hdr_valid <= next_hv;
			tx_none      <= next_none;
			tx_done      <= next_done;
		end
	end

	//=============================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic [3:0] sent;
	logic [7:0] rx_snap;
	logic [7:0] rd_snap;
	logic       pick_ok;
	assign rx_snap = mem[0][cpu_off];
	assign rd_snap = mem[cpu_buf][cpu_off];
	always_ff @(posedge clk) begin
		if (srst || st == CMBS_IDLE) begin
			sent <= 4'h0;
		end else if (pop) begin
			sent <= sent + 4'h1;
		end
	end
	always_comb begin
		pick_ok = 1'b1;
		for (int j = 0; j < NUM_TX; j++) begin
			if (!tx_empty[j] && (mem[j+1][OFF_PRIO] < win_prio ||
			    (mem[j+1][OFF_PRIO] == win_prio && 2'(j) < win_idx))) begin
				pick_ok = 1'b0;
			end
		end
	end

	sequence s_pick;
		sof_req && st == CMBS_IDLE && win_any;
	endsequence
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence

	a_rx_write_ignored: assert property (cpu.sel && cpu.wr && is_buf(cpu.addr) && cpu_buf == 2'h0
		&& !rx_hdr_we && !rx_byte_we |=> mem[0][$past(cpu_off)] == $past(rx_snap))
		else $error("CPU write changed receive buffer");
	a_tx_write_store: assert property (cpu_tx_wr |=> mem[$past(cpu_buf)][$past(cpu_off)] == $past(cpu.wdata))
		else $error("CPU write to transmit buffer not stored");
	a_read_any_buf: assert property (cpu.sel && cpu.rd && is_buf(cpu.addr) && cpu_off <= OFF_LEN
		|=> cpu_rdata == $past(rd_snap))
		else $error("Buffer read returned wrong byte");
	a_unused_zero: assert property (cpu.sel && cpu.rd && (!is_buf(cpu.addr) || cpu_off > OFF_PRIO
		|| (cpu_off == OFF_PRIO && cpu_buf == 2'h0)) |=> cpu_rdata == 8'h00)
		else $error("Unused location read nonzero");
	a_pick_lowest: assert property (s_pick |-> pick_ok ##1 tx_hdr_valid && tx_buf_idx == $past(win_idx))
		else $error("Selected buffer is not lowest priority");
	a_pick_none: assert property (sof_req && st == CMBS_IDLE && tx_empty == 3'h7
		|=> tx_none && !tx_hdr_valid)
		else $error("Selection with all buffers empty");
	a_remote_nodata: assert property (tx_hdr_valid && tx_hdr.rtr |-> !push && !tx_valid)
		else $error("Remote frame sent data bytes");
	a_byte_count: assert property (tx_done |-> sent == $past(total) && $past(total) <= MAX_BYTES)
		else $error("Wrong number of data bytes sent");
	a_stall_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
		else $error("Stalled byte changed or lost");
	a_ext_layout: assert property (rx_hdr_we && rx_hdr.ide |=> mem[0][1][IDE_BIT]
		&& mem[0][1][SRR_BIT] == $past(rx_hdr.srr) && mem[0][3][RTR_EXT_BIT] == $past(rx_hdr.rtr))
		else $error("Extended header stored wrongly");
	a_std_layout: assert property (rx_hdr_we && !rx_hdr.ide |=> !mem[0][1][IDE_BIT]
		&& mem[0][0] == $past(rx_hdr.id[10:3]) && mem[0][1][RTR_STD_BIT] == $past(rx_hdr.rtr))
		else $error("Standard header stored wrongly");
endmodule : cmbs_store

// *** cmbs_engine.sv ***
// Behavioural protocol engine facing the message buffer store.
// Assumes the bench calls its tasks from one process, synchronous to clk.
`timescale 1ns/100ps
module cmbs_engine (
	// Clock
	input  wire logic       clk,
	// Receive side
	output logic            rx_hdr_we,
	output cmbs_pkg::cmbs_hdr_t rx_hdr,
	output logic            rx_byte_we,
	output logic [2:0]      rx_byte_idx,
	output logic [7:0]      rx_byte,
	// Transmit side
	output logic            sof_req,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       slow
);
	import cmbs_pkg::*;
	logic [7:0] got_q[$];
	initial begin
		rx_hdr_we = 1'b0;
		rx_hdr = '0;
		rx_byte_we = 1'b0;
		rx_byte_idx = 3'h0;
		rx_byte = 8'h00;
		sof_req = 1'b0;
		tx_ready = 1'b1;
	end
	//=============================================
	// Data sink, stalling every other cycle when slow
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			got_q.push_back(tx_data);
		end
	end
	//=============================================
	// Frame tasks; released header and data byte lines show inverted values, rx_byte_idx keeps its value
	task automatic recv_hdr(input cmbs_hdr_t h);
		@(posedge clk);
		#1;
		rx_hdr = h;
		rx_hdr_we = 1'b1;
		@(posedge clk);
		#1;
		rx_hdr_we = 1'b0;
		rx_hdr = ~h;
	endtask : recv_hdr
	task automatic recv_byte(input logic [2:0] i, input logic [7:0] b);
		@(posedge clk);
		#1;
		rx_byte_idx = i;
		rx_byte = b;
		rx_byte_we = 1'b1;
		@(posedge clk);
		#1;
		rx_byte_we = 1'b0;
		rx_byte = ~b;
	endtask : recv_byte
	task automatic start();
		@(posedge clk);
		#1;
		sof_req = 1'b1;
		@(posedge clk);
		#1;
		sof_req = 1'b0;
	endtask : start
endmodule : cmbs_engine

// *** tb.sv ***
// Self-checking bench for the message buffer store.
// Assumes cmbs_engine stands in for the protocol engine.
`timescale 1ns/100ps
module tb;
	import cmbs_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	cmbs_cpu_t   cpu = '0;
	logic        slow = 1'b0;
	logic [2:0]  tx_empty = 3'h7;
	logic [7:0]  cpu_rdata, tx_data, rd, rx_byte;
	logic [2:0]  rx_byte_idx;
	logic [1:0]  tx_buf_idx;
	logic        rx_hdr_we, rx_byte_we, sof_req, tx_hdr_valid, tx_none, tx_done, tx_valid, tx_ready;
	cmbs_hdr_t   rx_hdr, tx_hdr;
	logic [31:0] w;
	int          fail_count = 0;
	int          num_checks = 0;
	always #2 clk = ~clk;
	cmbs_store u_cmbs_store (.clk(clk), .srst(srst), .cpu(cpu), .cpu_rdata(cpu_rdata),
		.rx_hdr_we(rx_hdr_we), .rx_hdr(rx_hdr), .rx_byte_we(rx_byte_we), .rx_byte_idx(rx_byte_idx),
		.rx_byte(rx_byte), .tx_empty(tx_empty), .sof_req(sof_req), .tx_hdr_valid(tx_hdr_valid),
		.tx_hdr(tx_hdr), .tx_buf_idx(tx_buf_idx), .tx_none(tx_none), .tx_done(tx_done),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
	cmbs_engine u_cmbs_engine (.clk(clk), .rx_hdr_we(rx_hdr_we), .rx_hdr(rx_hdr),
		.rx_byte_we(rx_byte_we), .rx_byte_idx(rx_byte_idx), .rx_byte(rx_byte), .sof_req(sof_req),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .slow(slow));
	//=============================================
	// Helpers
	function automatic logic [31:0] pk(input logic [28:0] id, input logic s, input logic e, input logic r);
		pk = e ? {id[28:18], s, 1'b1, id[17:0], r} : {id[10:0], r, 1'b0, 19'h00000};
	endfunction : pk
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask : chk
	task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		cpu = '{1'b1, wr, ~wr, a, d};
		@(posedge clk);
		#1;
		cpu = '0;
		q = cpu_rdata;
	endtask : acc
	task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, rd);
		chk(nm, e, rd);
	endtask : rdchk
	task automatic load(input int b, input logic [28:0] id, input logic e, input logic r,
	                    input logic [3:0] dlc, input logic [7:0] pr);
		logic [31:0] v;
		v = pk(id, 1'b1, e, r);
		for (int i = 0; i < 4; i++) acc(1'b1, 12'(336 + b * 16 + i), v[31 - 8 * i -: 8], rd);
		for (int i = 4; i < 12; i++) acc(1'b1, 12'(336 + b * 16 + i), 8'(b * 16 + i), rd);
		acc(1'b1, 12'(348 + b * 16), {4'h0, dlc}, rd);
		acc(1'b1, 12'(349 + b * 16), pr, rd);
	endtask : load
	task automatic run(input logic [2:0] em, input logic [1:0] ei, input cmbs_hdr_t eh, input int n);
		int k;
		tx_empty = em;
		u_cmbs_engine.got_q.delete();
		u_cmbs_engine.start();
		if (n < 0) begin
			chk("tx_none", 1, tx_none);
			return;
		end
		chk("tx_hdr_valid", 1, tx_hdr_valid);
		chk("tx_buf_idx", ei, tx_buf_idx);
		chk("tx_hdr", eh, tx_hdr);
		for (k = 0; k < 60 && tx_done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 60) begin
			fail_count++;
			close_out();
		end
		chk("byte count", n, u_cmbs_engine.got_q.size());
		for (k = 0; k < n; k++) chk("tx_data", 8'(ei * 16 + 4 + k), u_cmbs_engine.got_q[k]);
		chk("tx_hdr_valid", 0, tx_hdr_valid);
	endtask : run
	//=============================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		chk("cpu_rdata", 0, cpu_rdata);
		chk("tx_hdr_valid", 0, tx_hdr_valid);
		u_cmbs_engine.recv_hdr('{29'h1ffffffe, 1'b1, 1'b1, 1'b1, 4'h8});
		for (int i = 0; i < 8; i++) u_cmbs_engine.recv_byte(3'(i), 8'(160 + i));
		w = pk(29'h1ffffffe, 1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++) rdchk("rx id", 12'(320 + i), w[31 - 8 * i -: 8]);
		rdchk("rx len", 12'h14c, 8'h08);
		acc(1'b1, 12'h140, 8'h55, rd);
		rdchk("rx id", 12'h140, w[31:24]);
		u_cmbs_engine.recv_hdr('{29'h7f1, 1'b0, 1'b0, 1'b0, 4'h2});
		for (int i = 0; i < 3; i++) u_cmbs_engine.recv_byte(3'(i), 8'(16 + i));
		w = pk(29'h7f1, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) rdchk("rx id", 12'(320 + i), w[31 - 8 * i -: 8]);
		rdchk("rx data", 12'h145, 8'h11);
		rdchk("rx data", 12'h146, 8'ha2);
		rdchk("rx prio", 12'h14d, 8'h00);
		load(0, 29'h12345678, 1'b1, 1'b0, 4'h3, 8'h05);
		load(1, 29'h5a3, 1'b0, 1'b1, 4'h4, 8'h03);
		load(2, 29'h123, 1'b0, 1'b0, 4'h8, 8'h03);
		rdchk("tx prio", 12'h16d, 8'h03);
		rdchk("tx data", 12'h17b, 8'h2b);
		rdchk("tx unused", 12'h15e, 8'h00);
		run(3'h0, 2'h1, '{29'h5a3, 1'b0, 1'b0, 1'b1, 4'h4}, 0);
		slow = 1'b1;
		run(3'h2, 2'h2, '{29'h123, 1'b0, 1'b0, 1'b0, 4'h8}, 8);
		run(3'h6, 2'h0, '{29'h12345678, 1'b1, 1'b1, 1'b0, 4'h3}, 3);
		run(3'h7, 2'h0, '0, -1);
		close_out();
	end
endmodule : tb
